// ===== nsm_core_model.sv
// behavioural core: takes requests through entry_start, entry_done, exc_return
// assumes core_req is registered on clk_sys; drives at falling edges
`timescale 1ns/1ps
`default_nettype none

module nsm_core_model (
  // clock and reset
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  // controller side
  input wire nsm_pkg::nsm_core_req_t      core_req,
  output nsm_pkg::nsm_core_evt_t          core_evt,
  // test control and log
  input wire logic                        run,
  input wire logic [3:0]                  gap,
  output logic [nsm_pkg::VEC_W-1:0]       last_vec,
  output logic [7:0]                      n_taken
);
  // ==========================================================
  // one exception at a time; gap widens entry so late arrivals fit
  initial begin
    core_evt = '0;
    last_vec = '0;
    n_taken  = 8'h00;
    forever begin
      @(negedge clk_sys);
      if (rst_n && run && core_req.req === 1'b1) begin
        core_evt.entry_start = 1'b1;
        @(negedge clk_sys);
        core_evt.entry_start = 1'b0;
        repeat (gap) @(negedge clk_sys);
        last_vec = core_req.vec;
        core_evt.entry_done = 1'b1;
        @(negedge clk_sys);
        core_evt.entry_done = 1'b0;
        n_taken = n_taken + 8'h01;
        repeat (4) @(negedge clk_sys);
        core_evt.exc_return = 1'b1;
        @(negedge clk_sys);
        core_evt.exc_return = 1'b0;
      end
    end
  end
endmodule : nsm_core_model
`default_nettype wire

// ===== nsm_ctrl.sv
// nested_irq_source_map top: pending, priority, masking and exception entry toward the core
// assumes core handshake strobes and software set strobes come from clk_sys logic
`default_nettype none
`timescale 1ns/1ps

module nsm_ctrl (
  // clock and reset
  input  wire logic                                       clk_sys,
  input  wire logic                                       rst_n,
  // peripheral and gpio sources
  input  wire nsm_pkg::nsm_periph_t                       periph,
  input  wire logic [nsm_pkg::NUM_GPIO-1:0]               gpio_pin,
  input  wire nsm_pkg::nsm_trig_t [nsm_pkg::NUM_GPIO-1:0] gpio_trig,
  // watchdog
  input  wire logic                                       watchdog_source_irq,
  // system exceptions
  input  wire logic                                       pendsv_set,
  input  wire logic                                       systick_irq,
  // software control
  input  wire logic [nsm_pkg::NUM_LINES-1:0]              sw_set_pend,
  input  wire logic [nsm_pkg::NUM_SRC-1:0]                src_enable,
  input  wire logic [nsm_pkg::NUM_SRC-1:0][nsm_pkg::PRIO_W-1:0] src_prio,
  input  wire logic [nsm_pkg::LVL_W-1:0]                  mask_level,
  // core handshake
  input  wire nsm_pkg::nsm_core_evt_t                     core_evt,
  output nsm_pkg::nsm_core_req_t                          core_req,
  output logic                                            late_arrival,
  // status
  output logic [nsm_pkg::NUM_SRC-1:0]                     pend,
  output logic [nsm_pkg::NUM_SRC-1:0]                     active,
  output logic                                            nmi_active,
  output logic [nsm_pkg::LVL_W-1:0]                       cur_level
);
  // ==========================================================
  // source mapping
  logic [nsm_pkg::NUM_LINES-1:0] lines;

  nsm_src_map u_map (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .periph    (periph),
    .gpio_pin  (gpio_pin),
    .gpio_trig (gpio_trig),
    .lines     (lines)
  );

  // ==========================================================
  // helpers
  function automatic logic [nsm_pkg::VEC_W-1:0] vec_of(logic [nsm_pkg::IDX_W-1:0] idx);
    if (idx == 6'(nsm_pkg::IDX_PENDSV))
      vec_of = nsm_pkg::VEC_PENDSV;
    else if (idx == 6'(nsm_pkg::IDX_SYSTICK))
      vec_of = nsm_pkg::VEC_SYSTICK;
    else
      vec_of = nsm_pkg::VEC_EXT_BASE + idx;
  endfunction : vec_of

  // most urgent member of a set: lowest priority value, lowest index on ties
  function automatic logic [nsm_pkg::IDX_W:0] pick(logic [nsm_pkg::NUM_SRC-1:0] set,
                                                   logic [nsm_pkg::NUM_SRC-1:0][nsm_pkg::PRIO_W-1:0] pr);
    logic [nsm_pkg::LVL_W-1:0] best;
    pick = '0;
    best = nsm_pkg::LVL_NONE;
    for (int i = 0; i < nsm_pkg::NUM_SRC; i++) begin
      if (set[i] && {1'b0, pr[i]} < best) begin
        best = {1'b0, pr[i]};
        pick = {1'b1, 6'(i)};
      end
    end
  endfunction : pick

  // ==========================================================
  // entry state
  typedef enum logic [1:0] {
    NSM_IDLE  = 2'b00,
    NSM_ENTRY = 2'b01
  } nsm_state_t;

  nsm_state_t                    state, next_state;
  logic                          nmi_pend, next_nmi_pend, next_nmi_active, wdog_prev, next_wdog_prev;
  logic [nsm_pkg::NUM_SRC-1:0]   next_pend, next_active, hw_set, take_clr, ret_clr, eligible;
  logic [nsm_pkg::IDX_W-1:0]     sel_idx, next_sel_idx;
  logic                          sel_nmi, next_sel_nmi;
  logic                          next_late;
  logic [nsm_pkg::LVL_W-1:0]     next_level, thresh, act_prio;
  logic [nsm_pkg::IDX_W:0]       best, act_top, next_top;
  nsm_pkg::nsm_core_req_t        next_req;

  always_comb begin
    // hardware and software set sources
    hw_set = {systick_irq, pendsv_set, lines | sw_set_pend};
    // threshold: running level and software mask, whichever is more urgent
    thresh = (cur_level < mask_level) ? cur_level : mask_level;
    for (int i = 0; i < nsm_pkg::NUM_SRC; i++) begin
      eligible[i] = pend[i] & src_enable[i] & ({1'b0, src_prio[i]} < thresh);
    end
    best    = pick(eligible, src_prio);
    act_top = pick(active, src_prio);
    // commit on entry completion, from what the core currently sees
    take_clr = '0;
    next_nmi_active = nmi_active;
    if (state == NSM_ENTRY && core_evt.entry_done && core_req.req) begin
      if (sel_nmi)
        next_nmi_active = 1'b1;
      else
        take_clr[sel_idx] = 1'b1;
    end
    // return retires the most urgent active one, nmi first
    ret_clr = '0;
    if (core_evt.exc_return) begin
      if (nmi_active)
        next_nmi_active = 1'b0;
      else if (act_top[nsm_pkg::IDX_W])
        ret_clr[act_top[nsm_pkg::IDX_W-1:0]] = 1'b1;
    end
    // set wins over clear
    next_pend   = (pend & ~take_clr) | hw_set;
    next_active = (active & ~ret_clr) | take_clr;
    // watchdog edge latch, only internal source for nmi
    next_wdog_prev = watchdog_source_irq;
    next_nmi_pend  = (nmi_pend & ~(take_clr == '0 && next_nmi_active && !nmi_active))
                     | (watchdog_source_irq & ~wdog_prev);
    // running level
    next_top   = pick(next_active, src_prio);
    act_prio   = next_top[nsm_pkg::IDX_W]
                 ? {1'b0, src_prio[next_top[nsm_pkg::IDX_W-1:0]]} : nsm_pkg::LVL_NONE;
    next_level = act_prio;
    // selection, refreshed every cycle so late arrivals replace the vector
    next_sel_nmi = nmi_pend & ~nmi_active;
    next_sel_idx = best[nsm_pkg::IDX_W-1:0];
    next_req.nmi = next_sel_nmi;
    next_req.req = next_sel_nmi | best[nsm_pkg::IDX_W];
    next_req.vec = next_sel_nmi ? nsm_pkg::VEC_NMI
                 : (best[nsm_pkg::IDX_W] ? vec_of(best[nsm_pkg::IDX_W-1:0]) : nsm_pkg::VEC_NONE);
    // dropping nmi or the winner mid-entry would leave a stale vector; hold off while committing
    if (state == NSM_ENTRY && core_evt.entry_done) begin
      next_req     = '0;
      next_sel_nmi = 1'b0;
    end
    next_late  = (state == NSM_ENTRY) && !core_evt.entry_done && core_req.req
                 && next_req.req && next_req.vec != core_req.vec;
    next_state = state;
    unique case (state)
      NSM_IDLE:  if (core_evt.entry_start) next_state = NSM_ENTRY;
      NSM_ENTRY: if (core_evt.entry_done)  next_state = NSM_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state        <= NSM_IDLE;
      pend         <= '0;
      active       <= '0;
      nmi_pend     <= 1'b0;
      nmi_active   <= 1'b0;
      wdog_prev    <= 1'b0;
      sel_idx      <= '0;
      sel_nmi      <= 1'b0;
      core_req     <= '0;
      late_arrival <= 1'b0;
      cur_level    <= nsm_pkg::LVL_NONE;
    end else begin
      state        <= next_state;
      pend         <= next_pend;
      active       <= next_active;
      nmi_pend     <= next_nmi_pend;
      nmi_active   <= next_nmi_active;
      wdog_prev    <= next_wdog_prev;
      sel_idx      <= next_sel_idx;
      sel_nmi      <= next_sel_nmi;
      core_req     <= next_req;
      late_arrival <= next_late;
      cur_level    <= next_level;
    end
  end
endmodule : nsm_ctrl

`default_nettype wire

// ===== nsm_ctrl_properties.sv
// concurrent checks on the ports of nsm_ctrl
// assumes one clock domain, clk_sys, with synchronous active-low rst_n
`timescale 1ns/1ps
`default_nettype none

module nsm_ctrl_properties (
  // clock and reset
  input wire logic                             clk_sys,
  input wire logic                             rst_n,
  // watched ports
  input wire nsm_pkg::nsm_periph_t             periph,
  input wire logic                             watchdog_source_irq,
  input wire logic [nsm_pkg::NUM_LINES-1:0]    sw_set_pend,
  input wire logic [nsm_pkg::LVL_W-1:0]        mask_level,
  input wire nsm_pkg::nsm_core_req_t           core_req,
  input wire logic                             late_arrival,
  input wire logic [nsm_pkg::NUM_SRC-1:0]      pend
);
  // ==========================================================
  // clocking
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // assertions
  a_timer_or_line: assert property (|periph.timer |-> ##2 pend[0])
    else $error("timer source did not pend line 0");
  a_ctless_line_two: assert property (periph.contactless_front_end |-> ##2 pend[2])
    else $error("contactless source did not pend line 2");
  a_nmi_vector: assert property ($rose(watchdog_source_irq) |->
    ##[1:3] (core_req.nmi && core_req.vec == nsm_pkg::VEC_NMI))
    else $error("watchdog rise did not raise nmi request");
  a_unused_lines: assert property ($rose(|(pend[31:0] & 32'hfc00_0132)) |->
    $past(|(sw_set_pend & 32'hfc00_0132)))
    else $error("sourceless line became pending without software");
  a_mask_all_blocks: assert property ((mask_level == 3'h0) [*3] |->
    (!core_req.req || core_req.nmi))
    else $error("request issued while all priorities masked");
  a_sw_set_pend: assert property (|sw_set_pend |=>
    ((pend[31:0] & $past(sw_set_pend)) == $past(sw_set_pend)))
    else $error("software set did not pend line");
  a_late_new_vec: assert property (late_arrival |->
    (core_req.req && core_req.vec != $past(core_req.vec)))
    else $error("late arrival without vector change");
  a_vec_pending: assert property ((core_req.req && !core_req.nmi &&
    core_req.vec >= nsm_pkg::VEC_EXT_BASE) |-> pend[core_req.vec - nsm_pkg::VEC_EXT_BASE])
    else $error("vector shown for a line that is not pending");
endmodule : nsm_ctrl_properties

bind nsm_ctrl nsm_ctrl_properties nsm_ctrl_properties_inst (.clk_sys, .rst_n, .periph,
  .watchdog_source_irq, .sw_set_pend, .mask_level, .core_req, .late_arrival, .pend);
`default_nettype wire

// ===== nsm_src_map.sv
// nested_irq_source_map package and peripheral source map
// assumes on-chip peripheral sources run on clk_sys; gpio pins are asynchronous
`default_nettype none

package nsm_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_LINES = 32;
  localparam int NUM_SRC   = 34;
  localparam int NUM_GPIO  = 12;
  localparam int PRIO_W    = 2;
  localparam int LVL_W     = 3;
  localparam int IDX_W     = 6;
  localparam int VEC_W     = 6;
  // ==========================================================
  // line numbers
  localparam int LINE_TIMER   = 0;
  localparam int LINE_CTLESS  = 2;
  localparam int LINE_EEPROM  = 3;
  localparam int LINE_HOST    = 6;
  localparam int LINE_CONTACT = 7;
  localparam int LINE_PWRMGT  = 9;
  localparam int LINE_SPIM    = 10;
  localparam int LINE_I2CM    = 11;
  localparam int LINE_PWRCLK  = 12;
  localparam int LINE_GPIO_OR = 13;
  localparam int LINE_GPIO1   = 14;
  localparam int IDX_PENDSV   = 32;
  localparam int IDX_SYSTICK  = 33;
  // ==========================================================
  // vectors and levels
  localparam logic [VEC_W-1:0] VEC_NONE     = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI      = 6'h02;
  localparam logic [VEC_W-1:0] VEC_PENDSV   = 6'h0e;
  localparam logic [VEC_W-1:0] VEC_SYSTICK  = 6'h0f;
  localparam logic [VEC_W-1:0] VEC_EXT_BASE = 6'h10;
  localparam logic [LVL_W-1:0] LVL_NONE     = 3'h4;
  localparam logic [NUM_LINES-1:0] RST_LINES = 32'h0000_0000;
  // ==========================================================
  // gpio trigger modes
  typedef enum logic [2:0] {
    NSM_TRIG_OFF  = 3'h0,
    NSM_TRIG_RISE = 3'h1,
    NSM_TRIG_FALL = 3'h2,
    NSM_TRIG_BOTH = 3'h3,
    NSM_TRIG_HIGH = 3'h4,
    NSM_TRIG_LOW  = 3'h5
  } nsm_trig_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] timer;
    logic       contactless_front_end;
    logic       eeprom;
    logic       host_buf;
    logic       contact;
    logic       power_mgmt_unit;
    logic       spim_buf;
    logic       i2cm_buf;
    logic       power_clock_reset_unit;
  } nsm_periph_t;

  typedef struct packed {
    logic entry_start;
    logic entry_done;
    logic exc_return;
  } nsm_core_evt_t;

  typedef struct packed {
    logic             req;
    logic             nmi;
    logic [VEC_W-1:0] vec;
  } nsm_core_req_t;
endpackage : nsm_pkg

`timescale 1ns/1ps

module nsm_src_map (
  // clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  // on-chip sources
  input  wire nsm_pkg::nsm_periph_t                  periph,
  // gpio pins and trigger setup
  input  wire logic [nsm_pkg::NUM_GPIO-1:0]          gpio_pin,
  input  wire nsm_pkg::nsm_trig_t [nsm_pkg::NUM_GPIO-1:0] gpio_trig,
  // mapped lines
  output logic [nsm_pkg::NUM_LINES-1:0]              lines
);
  // ==========================================================
  // gpio synchroniser and trigger
  logic [nsm_pkg::NUM_GPIO-1:0]  meta, sync, prev, hit;
  logic [nsm_pkg::NUM_GPIO-1:0]  next_meta, next_sync, next_prev;
  logic [nsm_pkg::NUM_LINES-1:0] next_lines;

  function automatic logic trig_hit(nsm_pkg::nsm_trig_t m, logic cur, logic old);
    unique case (m)
      nsm_pkg::NSM_TRIG_RISE: trig_hit = cur & ~old;
      nsm_pkg::NSM_TRIG_FALL: trig_hit = ~cur & old;
      nsm_pkg::NSM_TRIG_BOTH: trig_hit = cur ^ old;
      nsm_pkg::NSM_TRIG_HIGH: trig_hit = cur;
      nsm_pkg::NSM_TRIG_LOW:  trig_hit = ~cur;
      default:                trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  genvar g;
  generate
    for (g = 0; g < nsm_pkg::NUM_GPIO; g++) begin : g_gpio
      assign hit[g] = trig_hit(gpio_trig[g], sync[g], prev[g]);
    end
  endgenerate

  always_comb begin
    next_meta  = gpio_pin;
    next_sync  = meta;
    next_prev  = sync;
    next_lines = nsm_pkg::RST_LINES;
    next_lines[nsm_pkg::LINE_TIMER]   = |periph.timer;
    next_lines[nsm_pkg::LINE_CTLESS]  = periph.contactless_front_end;
    next_lines[nsm_pkg::LINE_EEPROM]  = periph.eeprom;
    next_lines[nsm_pkg::LINE_HOST]    = periph.host_buf;
    next_lines[nsm_pkg::LINE_CONTACT] = periph.contact;
    next_lines[nsm_pkg::LINE_PWRMGT]  = periph.power_mgmt_unit;
    next_lines[nsm_pkg::LINE_SPIM]    = periph.spim_buf;
    next_lines[nsm_pkg::LINE_I2CM]    = periph.i2cm_buf;
    next_lines[nsm_pkg::LINE_PWRCLK]  = periph.power_clock_reset_unit | (|hit);
    next_lines[nsm_pkg::LINE_GPIO_OR] = |hit;
    next_lines[nsm_pkg::LINE_GPIO1 +: nsm_pkg::NUM_GPIO] = hit;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta  <= '0;
      sync  <= '0;
      prev  <= '0;
      lines <= nsm_pkg::RST_LINES;
    end else begin
      meta  <= next_meta;
      sync  <= next_sync;
      prev  <= next_prev;
      lines <= next_lines;
    end
  end
endmodule : nsm_src_map

`default_nettype wire

// ===== testbench.sv
// self-checking bench for nsm_ctrl with the core model
// assumes clk_sys at 100 MHz; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                          clk_sys, rst_n, wdog, run, late_arrival, nmi_active, late_seen;
  logic                          pendsv, systick;
  nsm_pkg::nsm_periph_t          periph;
  logic [11:0]                   gpio_pin;
  nsm_pkg::nsm_trig_t [11:0]     gpio_trig;
  logic [31:0]                   sw_set_pend;
  logic [33:0]                   src_enable, pend, active;
  logic [33:0][1:0]              src_prio;
  logic [2:0]                    mask_level, cur_level;
  logic [3:0]                    gap;
  nsm_pkg::nsm_core_evt_t        core_evt;
  nsm_pkg::nsm_core_req_t        core_req;
  logic [5:0]                    last_vec;
  logic [7:0]                    n_taken;
  int                            fail_count, n_checks;

  nsm_ctrl nsm_ctrl_inst (.clk_sys, .rst_n, .periph, .gpio_pin, .gpio_trig, .watchdog_source_irq(wdog),
    .pendsv_set(pendsv), .systick_irq(systick), .sw_set_pend, .src_enable, .src_prio, .mask_level,
    .core_evt, .core_req, .late_arrival, .pend, .active, .nmi_active, .cur_level);
  nsm_core_model nsm_core_model_inst (.clk_sys, .rst_n, .core_req, .core_evt, .run, .gap, .last_vec, .n_taken);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // late_arrival is a one-cycle pulse; latched so a scenario can judge it afterwards
  always @(posedge clk_sys) late_seen <= rst_n ? (late_seen | (late_arrival === 1'b1)) : 1'b0;
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic do_reset;
    rst_n = 1'b0;
    run = 1'b0;
    gap = 4'h0;
    wdog = 1'b0;
    pendsv = 1'b0;
    systick = 1'b0;
    periph = '0;
    gpio_pin = 12'h000;
    for (int k = 0; k < 12; k++) gpio_trig[k] = nsm_pkg::NSM_TRIG_OFF;
    sw_set_pend = '0;
    src_enable = '1;
    src_prio = {34{2'h1}};
    mask_level = 3'h4;
    tick(2);
    rst_n = 1'b1;
    chk("cur_level", cur_level, nsm_pkg::LVL_NONE);
    chk("pend", pend, 34'h0);
  endtask : do_reset
  // ==========================================================
  // scenarios
  task automatic t_map;
    int ln [12];
    logic [31:0] exp;
    ln = '{12, 11, 10, 9, 7, 6, 3, 2, 0, 0, 0, 0};
    exp = '0;
    do_reset();
    for (int i = 0; i < 12; i++) begin
      periph = nsm_pkg::nsm_periph_t'(12'h001 << i);
      tick(3);
      periph = '0;
      exp[ln[i]] = 1'b1;
      chk("mapped pend", pend[31:0], exp);
    end
  endtask : t_map
  task automatic t_gpio;
    do_reset();
    gpio_trig[0] = nsm_pkg::NSM_TRIG_RISE;
    gpio_trig[1] = nsm_pkg::NSM_TRIG_FALL;
    gpio_trig[2] = nsm_pkg::NSM_TRIG_BOTH;
    gpio_trig[3] = nsm_pkg::NSM_TRIG_HIGH;
    gpio_trig[4] = nsm_pkg::NSM_TRIG_LOW;
    for (int k = 5; k < 12; k++) gpio_trig[k] = nsm_pkg::NSM_TRIG_RISE;
    tick(8);
    chk("gpio low", pend[31:0], 32'h0004_3000);
    gpio_pin = 12'hfff;
    tick(8);
    chk("gpio rise", pend[31:0], 32'h03ff_7000);
    gpio_pin = 12'hffd;
    tick(8);
    chk("gpio fall", pend[31:0], 32'h03ff_f000);
  endtask : t_gpio
  task automatic t_sysexc;
    do_reset();
    src_prio[32] = 2'h2;
    systick = 1'b1;
    pendsv = 1'b1;
    tick(1);
    systick = 1'b0;
    pendsv = 1'b0;
    tick(2);
    chk("sys pend", pend[33:32], 2'h3);
    chk("systick req", {core_req.req, core_req.vec}, {1'b1, nsm_pkg::VEC_SYSTICK});
  endtask : t_sysexc
  task automatic t_core;
    do_reset();
    src_prio[2] = 2'h2;
    src_prio[3] = 2'h0;
    gap = 4'h8;
    run = 1'b1;
    periph.contactless_front_end = 1'b1;
    for (int i = 0; i < 20 && core_evt.entry_start !== 1'b1; i++) @(posedge clk_sys);
    @(negedge clk_sys);
    periph = '0;
    periph.eeprom = 1'b1;
    tick(2);
    periph = '0;
    for (int i = 0; i < 40 && n_taken !== 8'h01; i++) @(posedge clk_sys);
    chk("late vec", last_vec, 6'h13);
    chk("late flag", late_seen, 1'b1);
    chk("active late", {active[3:2], cur_level}, {2'b10, 3'h0});
    for (int i = 0; i < 60 && n_taken !== 8'h02; i++) @(posedge clk_sys);
    chk("second vec", last_vec, 6'h12);
    @(negedge clk_sys);
    run = 1'b0;
  endtask : t_core
  task automatic t_mask;
    do_reset();
    src_prio[1] = 2'h3;
    src_prio[6] = 2'h3;
    mask_level = 3'h0;
    sw_set_pend = 32'h0000_0042;
    tick(1);
    sw_set_pend = '0;
    tick(3);
    chk("sw pend", pend[6:0], 7'h42);
    chk("masked req", core_req.req, 1'b0);
    mask_level = 3'h3;
    tick(3);
    chk("level 3 req", core_req.req, 1'b0);
    mask_level = 3'h4;
    tick(3);
    chk("unmasked req", {core_req.req, core_req.vec}, {1'b1, 6'h11});
    mask_level = 3'h0;
    wdog = 1'b1;
    tick(3);
    chk("nmi req", {core_req.nmi, core_req.vec}, {1'b1, nsm_pkg::VEC_NMI});
    wdog = 1'b0;
    run = 1'b1;
    tick(3);
    chk("nmi taken", {nmi_active, last_vec}, {1'b1, nsm_pkg::VEC_NMI});
    tick(6);
    chk("nmi retired", {nmi_active, core_req.req}, 2'b00);
    run = 1'b0;
  endtask : t_mask
  // ==========================================================
  // run control
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    fail_count = 0;
    n_checks = 0;
    do_reset();
    t_map();
    t_gpio();
    t_sysexc();
    t_core();
    t_mask();
    final_report();
  end
endmodule : testbench
`default_nettype wire
